// File: rtl/setpoint_pkg.sv
// Package of register map, field codes and carrier types for the setpoint comparators
package setpoint_pkg;

  // Widths
  localparam int WEIGHT_W   = 24;               // Signed sample width
  localparam int NUM_CMP    = 5;                // Comparator count
  localparam int TEN_PCT_DIV = 10;              // Threshold is one tenth of target

  // Register byte offsets
  localparam logic [7:0] TARGET_OFF   = 8'h00;  // Target value
  localparam logic [7:0] TOL_POS_OFF  = 8'h04;  // Positive tolerance
  localparam logic [7:0] TOL_NEG_OFF  = 8'h08;  // Negative tolerance
  localparam logic [7:0] STATUS_OFF   = 8'h0c;  // Zone and comparator outputs
  localparam logic [7:0] CMP_BASE_OFF = 8'h10;  // First comparator block
  localparam logic [7:0] CMP_STRIDE   = 8'h10;  // Bytes per comparator block
  localparam logic [3:0] CMP_CFG_SUB  = 4'h0;   // Source and operator
  localparam logic [3:0] CMP_LO_SUB   = 4'h4;   // Low limit
  localparam logic [3:0] CMP_HI_SUB   = 4'h8;   // High limit

  // Field positions
  localparam int CFG_OP_LSB  = 0;               // Operator field bits 2:0
  localparam int CFG_SRC_LSB = 4;               // Source field bits 6:4
  localparam int ST_CMP_LSB  = 4;               // Comparator bits in status
  localparam int ST_EN_BIT   = 3;               // Zone enable bit in status

  // Reset values
  localparam logic [WEIGHT_W-1:0] LIMIT_RST = 24'h000000;  // Limits and target

  // Comparator source selection
  typedef enum logic [2:0] {
    SRC_GROSS     = 3'b000,
    SRC_DISP      = 3'b001,
    SRC_DISP_ABS  = 3'b010,
    SRC_RATE      = 3'b011,
    SRC_RATE_ABS  = 3'b100
  } src_type;

  // Comparator operator
  typedef enum logic [2:0] {
    OP_LT      = 3'b000,
    OP_LE      = 3'b001,
    OP_EQ      = 3'b010,
    OP_GE      = 3'b011,
    OP_GT      = 3'b100,
    OP_WITHIN  = 3'b101,
    OP_OUTSIDE = 3'b110
  } op_type;

  // Live measurement sample
  typedef struct packed {
    logic                       valid;   // New sample strobe
    logic signed [WEIGHT_W-1:0] gross;   // Gross weight
    logic signed [WEIGHT_W-1:0] disp;    // Displayed weight
    logic signed [WEIGHT_W-1:0] rate;    // Rate
  } sample_type;

  // One comparator's setup
  typedef struct packed {
    src_type                    src;
    op_type                     op;
    logic signed [WEIGHT_W-1:0] lo;
    logic signed [WEIGHT_W-1:0] hi;
  } cmp_cfg_type;

  // Discrete outputs
  typedef struct packed {
    logic                 zone_under;
    logic                 zone_ok;
    logic                 zone_over;
    logic [NUM_CMP-1:0]   cmp;
  } dout_type;

endpackage : setpoint_pkg

// File: rtl/weight_setpoint_comparators.sv
// Tolerance zone classifier and five comparators with an APB register file
// Register map, one aligned 32-bit word per register
//   0x00  target value, signed, low 24 bits used
//   0x04  positive tolerance, signed, low 24 bits used
//   0x08  negative tolerance, signed, low 24 bits used
//   0x0c  status, read-only
//           bit 0    over zone output
//           bit 1    tolerance ok output
//           bit 2    under zone output
//           bit 3    zone enable, gross above a tenth of target
//           bits 8:4 comparator outputs, comparator 0 in bit 4
//   0x10 + 0x10*k  comparator k setup, k from 0 to 4
//           +0  operator in bits 2:0, source in bits 6:4
//           +4  low limit, signed
//           +8  high limit, signed
//
// Operator codes
//   0 less, 1 less or equal, 2 equal, 3 greater or equal,
//   4 greater, 5 strictly within range, 6 outside range inclusive,
//   7 forces the output off
//
// Source codes
//   0 gross, 1 displayed, 2 absolute displayed, 3 rate,
//   4 absolute rate, 5 to 7 fall back to gross
//
// Bus timing
//   The setup edge decodes the address and loads read data,
//   ready and the error flag, so the access phase ends after
//   exactly one cycle with no wait states.
//   A write lands at the access edge at which the master sees
//   ready, never at the setup edge, so a master that aborts
//   before ready leaves every register untouched.
//   Unaligned and unmapped addresses answer with the error
//   flag and never write anything.
//   Writes to the status word are ignored.
//   Bits 31:24 of write data are dropped; reads sign-extend.
//
// Sample timing
//   Outputs change only on an edge with the sample strobe high
//   and then hold until the next strobe.
//   Each evaluation uses limits registered before that edge,
//   so a limit written at the same edge takes effect on the
//   following sample.
//
// Zone arithmetic
//   Zones always use gross weight.
//   The enable test is ten times gross against target, which
//   avoids a divider and any rounding of the tenth.
//   Sums are widened so no limit setting can wrap around.
//   Both tolerance edges count as tolerance ok.
//
// Comparator hazards
//   Nothing is latched: a comparator that stops matching drops
//   its output at the very next sample.
//   An absolute value of the most negative sample needs one
//   extra bit, so sources are carried one bit wider.
`timescale 1ns/1ps
`default_nettype none

module weight_setpoint_comparators (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Measurement path
  input  wire setpoint_pkg::sample_type sample,
  // Discrete outputs
  output setpoint_pkg::dout_type       dout
);

  localparam int W = setpoint_pkg::WEIGHT_W;
  localparam int N = setpoint_pkg::NUM_CMP;

  // Whole module state
  typedef struct packed {
    logic signed [W-1:0]                   target;   // Target value
    logic signed [W-1:0]                   tol_pos;  // Positive tolerance
    logic signed [W-1:0]                   tol_neg;  // Negative tolerance
    setpoint_pkg::cmp_cfg_type [N-1:0]     cmp;      // Comparator setups
    logic                                  zone_en;  // Threshold passed
    setpoint_pkg::dout_type                dout;     // Registered outputs
    logic [31:0]                           prdata;   // Read data
    logic                                  pready;   // Access answer
    logic                                  pslverr;  // Unmapped answer
  } state_type;

  state_type state_r;   // Registered state
  state_type state_nxt; // Next state

  // Absolute value of a signed sample
  function automatic logic signed [W:0] abs_val(input logic signed [W-1:0] v);
    logic signed [W:0] e;
    e = {v[W-1], v};
    abs_val = (e < 0) ? -e : e;
  endfunction : abs_val

  // Pick comparator source, widened by one bit so absolute values fit
  function automatic logic signed [W:0] pick_src(input setpoint_pkg::src_type s,
                                                 input setpoint_pkg::sample_type m);
    unique case (s)
      setpoint_pkg::SRC_GROSS:    pick_src = {m.gross[W-1], m.gross};
      setpoint_pkg::SRC_DISP:     pick_src = {m.disp[W-1], m.disp};
      setpoint_pkg::SRC_DISP_ABS: pick_src = abs_val(m.disp);
      setpoint_pkg::SRC_RATE:     pick_src = {m.rate[W-1], m.rate};
      setpoint_pkg::SRC_RATE_ABS: pick_src = abs_val(m.rate);
      default:                    pick_src = {m.gross[W-1], m.gross};  // Unused codes
    endcase
  endfunction : pick_src

  // Evaluate one comparator against its limits
  function automatic logic eval_cmp(input setpoint_pkg::cmp_cfg_type c,
                                    input logic signed [W:0] x);
    logic signed [W:0] lo;
    logic signed [W:0] hi;
    lo = {c.lo[W-1], c.lo};
    hi = {c.hi[W-1], c.hi};
    unique case (c.op)
      setpoint_pkg::OP_LT:      eval_cmp = (x <  lo);
      setpoint_pkg::OP_LE:      eval_cmp = (x <= lo);
      setpoint_pkg::OP_EQ:      eval_cmp = (x == lo);
      setpoint_pkg::OP_GE:      eval_cmp = (x >= lo);
      setpoint_pkg::OP_GT:      eval_cmp = (x >  lo);
      // Low limit is the floor, high limit the ceiling
      setpoint_pkg::OP_WITHIN:  eval_cmp = (x > lo) && (x < hi);
      setpoint_pkg::OP_OUTSIDE: eval_cmp = (x <= lo) || (x >= hi);
      default:                  eval_cmp = 1'b0;  // Illegal code drives off
    endcase
  endfunction : eval_cmp

  // Zone arithmetic, widened against overflow
  logic signed [W+1:0] gross_x;   // Gross weight, widened
  logic signed [W+3:0] ten_x;     // Gross times ten, needs four more bits
  logic signed [W+1:0] tgt_x;     // Target, widened
  logic signed [W+1:0] low_x;     // Target minus negative tolerance
  logic signed [W+1:0] high_x;    // Target plus positive tolerance
  logic [3:0]          cmp_idx;   // Addressed comparator
  logic [3:0]          cmp_sub;   // Addressed field within comparator
  logic                cmp_hit;   // Address falls in comparator space
  logic [W-1:0]        wdat;      // Write data low bits
  logic                wr_fire;   // Access edge at which a write lands
  logic                zone_gate; // Gross above a tenth of target
  logic                below_low; // Gross under the lower tolerance edge
  logic                above_high; // Gross over the upper tolerance edge

  // Next-state logic
  always_comb
  begin
    state_nxt = state_r;
    gross_x = {{2{sample.gross[W-1]}}, sample.gross};
    tgt_x   = {{2{state_r.target[W-1]}}, state_r.target};
    ten_x   = ({{2{gross_x[W+1]}}, gross_x} <<< 3) + ({{2{gross_x[W+1]}}, gross_x} <<< 1);
    low_x   = tgt_x - {{2{state_r.tol_neg[W-1]}}, state_r.tol_neg};
    high_x  = tgt_x + {{2{state_r.tol_pos[W-1]}}, state_r.tol_pos};
    wdat    = pwdata[W-1:0];
    cmp_sub = paddr[3:0];
    cmp_idx = 4'(paddr[7:4] - setpoint_pkg::CMP_BASE_OFF[7:4]);
    cmp_hit = (paddr >= setpoint_pkg::CMP_BASE_OFF) && (cmp_idx < 4'(N));
    // Only a mapped access in its completing cycle may write
    wr_fire = psel && penable && pwrite && state_r.pready && !state_r.pslverr;
    // Zone comparisons shared by the three zone outputs
    zone_gate  = (ten_x > tgt_x);
    below_low  = (gross_x < low_x);
    above_high = (gross_x > high_x);

    // Outputs update only when a new sample arrives
    if (sample.valid)
    begin
      // Enable zones once gross exceeds a tenth of target
      state_nxt.zone_en = zone_gate;
      // Mutually exclusive zone outputs, none while disabled
      state_nxt.dout.zone_under = zone_gate && below_low;
      state_nxt.dout.zone_ok    = zone_gate && !below_low
                                  && !above_high;
      state_nxt.dout.zone_over  = zone_gate && above_high
                                  && !below_low;
      // Every comparator recomputed from scratch, nothing held
      for (int i = 0; i < N; i++)
      begin
        state_nxt.dout.cmp[i] = eval_cmp(state_r.cmp[i],
                                         pick_src(state_r.cmp[i].src, sample));
      end
    end

    // APB answer is one cycle after setup; reads are decoded here, writes land later
    state_nxt.pready  = 1'b0;
    state_nxt.pslverr = 1'b0;
    if (psel && !penable)
    begin
      state_nxt.pready = 1'b1;
      state_nxt.prdata = 32'h00000000;
      if (paddr[1:0] != 2'b00)
      begin
        state_nxt.pslverr = 1'b1;  // Unaligned access refused
      end
      // Target value
      else if (paddr == setpoint_pkg::TARGET_OFF)
      begin
        state_nxt.prdata = {{(32-W){state_r.target[W-1]}}, state_r.target};
      end
      // Positive tolerance
      else if (paddr == setpoint_pkg::TOL_POS_OFF)
      begin
        state_nxt.prdata = {{(32-W){state_r.tol_pos[W-1]}}, state_r.tol_pos};
      end
      // Negative tolerance
      else if (paddr == setpoint_pkg::TOL_NEG_OFF)
      begin
        state_nxt.prdata = {{(32-W){state_r.tol_neg[W-1]}}, state_r.tol_neg};
      end
      // Status word
      else if (paddr == setpoint_pkg::STATUS_OFF)
      begin
        // Read-only; writes ignored
        state_nxt.prdata[2:0] = {state_r.dout.zone_under, state_r.dout.zone_ok, state_r.dout.zone_over};
        state_nxt.prdata[setpoint_pkg::ST_EN_BIT] = state_r.zone_en;
        state_nxt.prdata[setpoint_pkg::ST_CMP_LSB +: N] = state_r.dout.cmp;
      end
      // Comparator operator and source
      else if (cmp_hit && cmp_sub == setpoint_pkg::CMP_CFG_SUB)
      begin
        state_nxt.prdata[setpoint_pkg::CFG_OP_LSB +: 3]  = state_r.cmp[cmp_idx].op;
        state_nxt.prdata[setpoint_pkg::CFG_SRC_LSB +: 3] = state_r.cmp[cmp_idx].src;
      end
      // Comparator low limit
      else if (cmp_hit && cmp_sub == setpoint_pkg::CMP_LO_SUB)
      begin
        state_nxt.prdata = {{(32-W){state_r.cmp[cmp_idx].lo[W-1]}}, state_r.cmp[cmp_idx].lo};
      end
      // Comparator high limit
      else if (cmp_hit && cmp_sub == setpoint_pkg::CMP_HI_SUB)
      begin
        state_nxt.prdata = {{(32-W){state_r.cmp[cmp_idx].hi[W-1]}}, state_r.cmp[cmp_idx].hi};
      end
      else
      begin
        state_nxt.pslverr = 1'b1;  // Unmapped address
      end
    end

    // Write lands at the access edge at which the master sees ready;
    // the address is still held by the master, so it is decoded again
    if (wr_fire)
    begin
      // Target value
      if (paddr == setpoint_pkg::TARGET_OFF)
      begin
        state_nxt.target = wdat;
      end
      // Positive tolerance
      else if (paddr == setpoint_pkg::TOL_POS_OFF)
      begin
        state_nxt.tol_pos = wdat;
      end
      // Negative tolerance
      else if (paddr == setpoint_pkg::TOL_NEG_OFF)
      begin
        state_nxt.tol_neg = wdat;
      end
      // Status word is read-only, nothing changes
      else if (paddr == setpoint_pkg::STATUS_OFF)
      begin
        state_nxt.zone_en = state_nxt.zone_en;
      end
      // Comparator operator and source
      else if (cmp_hit && cmp_sub == setpoint_pkg::CMP_CFG_SUB)
      begin
        state_nxt.cmp[cmp_idx].op  = setpoint_pkg::op_type'(pwdata[setpoint_pkg::CFG_OP_LSB +: 3]);
        state_nxt.cmp[cmp_idx].src = setpoint_pkg::src_type'(pwdata[setpoint_pkg::CFG_SRC_LSB +: 3]);
      end
      // Comparator low limit
      else if (cmp_hit && cmp_sub == setpoint_pkg::CMP_LO_SUB)
      begin
        state_nxt.cmp[cmp_idx].lo = wdat;
      end
      // Comparator high limit
      else if (cmp_hit && cmp_sub == setpoint_pkg::CMP_HI_SUB)
      begin
        state_nxt.cmp[cmp_idx].hi = wdat;
      end
      // Refused addresses never reach here, the error flag blocks them
      else
      begin
        state_nxt.target = state_nxt.target;
      end
    end
  end

  // State register; reset clears limits, outputs and bus answer
  // Reset leaves every comparator as less-than on gross weight
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata  = state_r.prdata;
  assign pready  = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign dout    = state_r.dout;

endmodule : weight_setpoint_comparators

`default_nettype wire

// File: verification/discrete_load.sv
// Relay bank model that follows the discrete outputs
`timescale 1ns/1ps
`default_nettype none

module discrete_load (
  // Clock
  input  wire logic                   pclk,
  // Discrete outputs from the block
  input  wire setpoint_pkg::dout_type dout,
  // Energized relay coils
  output logic [7:0]                  coils
);
  // Coils pull in one cycle after an output rises
  always_ff @(posedge pclk)
    coils <= dout;
endmodule : discrete_load

`default_nettype wire

// File: verification/setpoint_props.sv
// Checker of zone classification, output holding and bus answer timing
`timescale 1ns/1ps
`default_nettype none

module setpoint_props (
  // Clock and reset
  input wire logic                     pclk,
  input wire logic                     presetn,
  // APB slave side
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  // Measurement and outputs
  input wire setpoint_pkg::sample_type sample,
  input wire setpoint_pkg::dout_type   dout
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic signed [31:0] t_r, tp_r, tn_r;  // Shadow target and tolerances
  logic signed [31:0] g;                // Gross weight, widened
  logic               en, und, ok, ovr; // Expected zone state

  // Shadow copies follow writes at the completing access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t_r  <= '0;
      tp_r <= '0;
      tn_r <= '0;
    end
    else if (psel && penable && pready && !pslverr && pwrite)
    begin
      if (paddr == setpoint_pkg::TARGET_OFF) t_r <= $signed(pwdata[23:0]);
      if (paddr == setpoint_pkg::TOL_POS_OFF) tp_r <= $signed(pwdata[23:0]);
      if (paddr == setpoint_pkg::TOL_NEG_OFF) tn_r <= $signed(pwdata[23:0]);
    end
  end

  // Zone expectation from the live sample
  assign g   = sample.gross;
  assign en  = 10 * g > t_r;
  assign und = en && g < t_r - tn_r;
  assign ok  = en && g >= t_r - tn_r && g <= t_r + tp_r;
  assign ovr = en && g > t_r + tp_r;

  zone_excl_a: assert property ($onehot0({dout.zone_under, dout.zone_ok, dout.zone_over}))
    else $error("more than one zone output active");
  zone_gate_a: assert property (sample.valid && !en |=> !(dout.zone_under || dout.zone_ok || dout.zone_over))
    else $error("zone output active below threshold");
  under_zone_a: assert property (sample.valid |=> dout.zone_under == $past(und))
    else $error("under zone output wrong");
  ok_zone_a: assert property (sample.valid |=> dout.zone_ok == $past(ok))
    else $error("tolerance ok output wrong");
  over_zone_a: assert property (sample.valid |=> dout.zone_over == $past(ovr))
    else $error("over zone output wrong");
  out_hold_a: assert property (!sample.valid |=> $stable(dout))
    else $error("outputs changed without a sample");
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");

  // Main scenarios
  cover property (sample.valid ##1 dout.zone_under);
  cover property (sample.valid ##1 dout.zone_ok);
  cover property (sample.valid ##1 dout.zone_over);
endmodule : setpoint_props

bind weight_setpoint_comparators setpoint_props props_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .sample, .dout);

`default_nettype wire

// File: verification/weight_setpoint_comparators_tb_top.sv
// Bench of zone classifier, comparators and register access
`timescale 1ns/1ps
`default_nettype none

module weight_setpoint_comparators_tb_top;
  logic                     pclk = 1'b0;     // Bus clock
  logic                     presetn = 1'b0;  // Reset, active low
  logic                     psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]               paddr = 8'h00;
  logic [31:0]              pwdata = 32'h00000000;
  logic [31:0]              prdata, rd;      // Read data and last word read
  logic                     pready, pslverr, er;
  setpoint_pkg::sample_type sample = '0;     // Live measurement
  setpoint_pkg::dout_type   dout;
  logic [7:0]               coils;
  logic [7:0]               base;            // Comparator block address
  int                       err_count = 0, n_compared = 0, k, x;
  int                       zv[6] = '{100, 101, 979, 980, 1010, 1011};
  int                       cv[6] = '{-401, 199, 200, 300, 400, 401};

  always #5 pclk = ~pclk;

  weight_setpoint_comparators DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sample, .dout);
  discrete_load LOAD (.pclk, .dout, .coils);

  // Compare and count
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; only the watchdog ends the wait for ready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is settled mid-cycle and stands to the sampling edge
    @(negedge pclk);
    while (pready !== 1'b1)
      @(negedge pclk);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    {psel, penable} <= 2'b00;
  endtask : apb

  // One sample strobe, returns once outputs have updated
  task smp(input int v);
    @(posedge pclk);
    sample <= '{1'b1, 24'(v), 24'(-v), 24'(-v)};
    @(posedge pclk);
    sample.valid <= 1'b0;
    #1;
  endtask : smp

  // Expected zones as under, ok, over
  function automatic logic [2:0] zexp(int g, int t, int tp, int tn);
    if (10 * g <= t) return 3'b000;
    return {g < t - tn, g >= t - tn && g <= t + tp, g > t + tp};
  endfunction : zexp

  // Expected comparator result by operator code
  function automatic logic cexp(int op, int v, int lo, int hi);
    logic [6:0] r;
    r = {v <= lo || v >= hi, lo < v && v < hi, v > lo, v >= lo, v == lo, v <= lo, v < lo};
    return r[op];
  endfunction : cexp

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // Watchdog
  initial
  begin
    #100000;
    err_count++;
    finish_test;
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, setpoint_pkg::STATUS_OFF, 32'h0);
    chk("status after reset", rd, 32'h0);
    apb(1'b0, 8'hf0, 32'h0);
    chk("unmapped error", 32'(er), 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    chk("unaligned error", 32'(er), 32'h1);
    $display("test reset and bus done");
    apb(1'b1, setpoint_pkg::TARGET_OFF, 32'h3e8);
    apb(1'b1, setpoint_pkg::TOL_POS_OFF, 32'ha);
    apb(1'b1, setpoint_pkg::TOL_NEG_OFF, 32'h14);
    apb(1'b0, setpoint_pkg::TARGET_OFF, 32'h0);
    chk("target readback", rd, 32'h3e8);
    foreach (zv[i])
    begin
      smp(zv[i]);
      chk("zones", 32'({dout.zone_under, dout.zone_ok, dout.zone_over}), 32'(zexp(zv[i], 1000, 10, 20)));
    end
    @(posedge pclk);
    #1;
    chk("relay coils", 32'(coils), 32'(dout));
    apb(1'b0, setpoint_pkg::STATUS_OFF, 32'h0);
    chk("status over", 32'(rd[3:0]), 32'h9);
    $display("test zones done");
    for (int op = 0; op < 7; op++)
    begin
      k = op % 5;
      base = setpoint_pkg::CMP_BASE_OFF + 8'(k * 16);
      apb(1'b1, base, 32'(op) | 32'(k << 4));
      apb(1'b1, base + 8'h04, 32'hc8);
      apb(1'b1, base + 8'h08, 32'h190);
      foreach (cv[j])
      begin
        smp(cv[j]);
        x = (k == 1 || k == 3) ? -cv[j] : cv[j];
        x = (k == 2 || k == 4) ? (cv[j] < 0 ? -cv[j] : cv[j]) : x;
        chk("comparator", 32'(dout.cmp[k]), 32'(cexp(op, x, 200, 400)));
      end
    end
    $display("test comparators done");
    finish_test;
  end
endmodule : weight_setpoint_comparators_tb_top

`default_nettype wire
